// ===== verilog/ffc_pkg.sv
// constants for the motion adaptive field/frame control block
package ffc_pkg;
    // register byte offsets
    localparam logic [3:0] sens_offset = 4'h0;
    localparam logic [3:0] film_offset = 4'h4;
    localparam logic [3:0] rate_offset = 4'h8;
    localparam logic [3:0] status_offset = 4'hc;
    // sensitivity field, 0 = frame extreme, 15 = field extreme
    localparam int sens_lsb = 0;
    localparam int sens_width = 4;
    localparam logic [3:0] sens_frame = 4'h0;
    localparam logic [3:0] sens_field = 4'hf;
    localparam logic [3:0] sens_reset = 4'h9;
    // film override register: mode bits [1:0], phase bit [2]
    localparam int film_mode_lsb = 0;
    localparam int film_phase_bit = 2;
    // motion rate register: rate [1:0], film phase [2], cadence phase [6:4]
    localparam int rate_lsb = 0;
    localparam int rate_film_phase_bit = 2;
    localparam int rate_cad_lsb = 4;
    // status register: field id [0], cadence position [6:4]
    localparam int stat_field_bit = 0;
    localparam int stat_cad_lsb = 4;
    // shared encodings for override mode and motion rate
    localparam logic [1:0] mode_normal = 2'h0;
    localparam logic [1:0] mode_film = 2'h1;
    localparam logic [1:0] mode_pulldown = 2'h2;
    localparam logic [1:0] mode_reset = 2'h0;
    // five field cadence, updates on positions 0 and 3 (three then two)
    localparam logic [2:0] cadence_len = 3'h5;
    localparam logic [2:0] cadence_hit_a = 3'h0;
    localparam logic [2:0] cadence_hit_b = 3'h3;
    localparam logic [31:0] read_zero = 32'h0000_0000;
endpackage

// ===== verilog/field_frame_ctrl.sv
// field/frame interpolation decision and keyframe position rate control
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// ===========================================================
// Summary of operation
// - sensitivity has sixteen levels, frame to field
// - sensitivity resets to nine
// - no detected motion forces frame combining
// - decision is made per picture region
// - progressive input always uses frame mode
// - only input motion and border changes count
// - normal override lets sensitivity alone decide
// - film override forces frame on matching fields
// - phase picks which field starts a frame
// - three-two override forces field mode on moving interlaced regions
// - override never alters stored sensitivity readback
// - unity size bypasses the interpolator
// - override and rate settings are global
// - effect load or save leaves settings alone
// - override and rate settings act independently
// - normal rate advances position every field
// - film rate advances once per frame, phased
// - three-two rate advances on film frame cadence
// - three-two phase has five cadence positions
module field_frame_ctrl #(
    parameter int motion_width = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic field_start,
    input wire logic field_id,
    input wire logic progressive,
    input wire logic unity_size,
    input wire logic effect_load,
    input wire logic region_valid,
    input wire logic [motion_width-1:0] region_motion,
    input wire logic border_change,
    input wire logic effect_motion,
    output logic region_out_valid,
    output logic region_frame_mode,
    output logic interp_bypass,
    output logic position_advance
);
    // the region sum below is sized for at most eight motion bits
    if (motion_width < 1 || motion_width > 8)
    begin : bad_motion_width
        $error("motion_width must be 1 to 8");
    end

    // =======================================================
    // registers
    logic [3:0] sens;
    logic [1:0] film_mode;
    logic film_phase;
    logic [1:0] rate;
    logic rate_film_phase;
    logic [2:0] cad_phase;
    logic cur_field;
    logic [2:0] cad_pos;

    // one setting shared by every channel and region; effect loads
    // carry no path into these, so recalling an effect cannot move them
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            sens <= ffc_pkg::sens_reset;
        else if (wr && addr == ffc_pkg::sens_offset)
            sens <= wdata[ffc_pkg::sens_lsb +: ffc_pkg::sens_width];
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            film_mode <= ffc_pkg::mode_reset;
            film_phase <= 1'b0;
        end
        else if (wr && addr == ffc_pkg::film_offset)
        begin
            // an illegal mode code falls back to normal
            if (wdata[ffc_pkg::film_mode_lsb +: 2] == 2'h3)
                film_mode <= ffc_pkg::mode_normal;
            else
                film_mode <= wdata[ffc_pkg::film_mode_lsb +: 2];
            film_phase <= wdata[ffc_pkg::film_phase_bit];
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rate <= ffc_pkg::mode_reset;
            rate_film_phase <= 1'b0;
            cad_phase <= 3'h0;
        end
        else if (wr && addr == ffc_pkg::rate_offset)
        begin
            if (wdata[ffc_pkg::rate_lsb +: 2] == 2'h3)
                rate <= ffc_pkg::mode_normal;
            else
                rate <= wdata[ffc_pkg::rate_lsb +: 2];
            rate_film_phase <= wdata[ffc_pkg::rate_film_phase_bit];
            // only five positions exist; larger codes clamp to the last
            if (wdata[ffc_pkg::rate_cad_lsb +: 3] >= ffc_pkg::cadence_len)
                cad_phase <= ffc_pkg::cadence_len - 3'h1;
            else
                cad_phase <= wdata[ffc_pkg::rate_cad_lsb +: 3];
        end
    end

    // =======================================================
    // field tracking
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cur_field <= 1'b0;
            cad_pos <= 3'h0;
        end
        else if (field_start)
        begin
            cur_field <= field_id;
            if (cad_pos == ffc_pkg::cadence_len - 3'h1)
                cad_pos <= 3'h0;
            else
                cad_pos <= cad_pos + 3'h1;
        end
    end

    // =======================================================
    // read back: sensitivity shows the stored value only
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata <= ffc_pkg::read_zero;
        else if (rd)
        begin
            rdata <= ffc_pkg::read_zero;
            unique case (addr)
                ffc_pkg::sens_offset:
                    rdata[ffc_pkg::sens_lsb +: ffc_pkg::sens_width] <= sens;
                ffc_pkg::film_offset:
                begin
                    rdata[ffc_pkg::film_mode_lsb +: 2] <= film_mode;
                    rdata[ffc_pkg::film_phase_bit] <= film_phase;
                end
                ffc_pkg::rate_offset:
                begin
                    rdata[ffc_pkg::rate_lsb +: 2] <= rate;
                    rdata[ffc_pkg::rate_film_phase_bit] <= rate_film_phase;
                    rdata[ffc_pkg::rate_cad_lsb +: 3] <= cad_phase;
                end
                ffc_pkg::status_offset:
                begin
                    rdata[ffc_pkg::stat_field_bit] <= cur_field;
                    rdata[ffc_pkg::stat_cad_lsb +: 3] <= cad_pos;
                end
                default:
                    rdata <= ffc_pkg::read_zero;
            endcase
        end
        else
            rdata <= ffc_pkg::read_zero;
    end

    // =======================================================
    // effective sensitivity, never written back to sens
    logic second_field;
    logic [3:0] eff_sens;

    // the field that follows its partner in the same frame matches it
    assign second_field = cur_field ^ film_phase;

    always_comb
    begin
        eff_sens = sens;
        unique case (film_mode)
            ffc_pkg::mode_film:
                if (second_field)
                    eff_sens = ffc_pkg::sens_frame;
            ffc_pkg::mode_pulldown:
                eff_sens = ffc_pkg::sens_field;
            default:
                eff_sens = sens;
        endcase
    end

    // =======================================================
    // per region decision
    logic moving;
    logic [8:0] level_sum;
    logic next_frame_mode;

    // transform motion from effects is deliberately ignored
    assign moving = (region_motion != '0) || border_change;
    assign level_sum = 9'(region_motion) + 9'(eff_sens);

    always_comb
    begin
        next_frame_mode = 1'b1;
        if (progressive)
            next_frame_mode = 1'b1;
        else if (!moving)
            next_frame_mode = 1'b1;
        else if (eff_sens == ffc_pkg::sens_frame)
            next_frame_mode = 1'b1;
        else if (eff_sens == ffc_pkg::sens_field)
            next_frame_mode = 1'b0;
        else
            // higher sensitivity tips smaller motion into field mode
            next_frame_mode = level_sum < 9'h010;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            region_out_valid <= 1'b0;
            region_frame_mode <= 1'b1;
        end
        else
        begin
            region_out_valid <= region_valid;
            if (region_valid)
                region_frame_mode <= next_frame_mode;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            interp_bypass <= 1'b0;
        else
            interp_bypass <= unity_size;
    end

    // =======================================================
    // keyframe position rate, uses its own phase only
    logic [3:0] cad_sum;
    logic [2:0] cad_idx;
    logic next_advance;

    assign cad_sum = {1'b0, cad_pos} + {1'b0, cad_phase};
    assign cad_idx = (cad_sum >= 4'(ffc_pkg::cadence_len)) ?
        3'(cad_sum - 4'(ffc_pkg::cadence_len)) : cad_sum[2:0];

    always_comb
    begin
        next_advance = 1'b0;
        unique case (rate)
            ffc_pkg::mode_film:
                next_advance = !(field_id ^ rate_film_phase);
            ffc_pkg::mode_pulldown:
                next_advance = cad_idx == ffc_pkg::cadence_hit_a ||
                    cad_idx == ffc_pkg::cadence_hit_b;
            default:
                next_advance = 1'b1;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            position_advance <= 1'b0;
        else
            position_advance <= field_start && next_advance;
    end

    // =======================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence sens_written;
        wr && addr == ffc_pkg::sens_offset;
    endsequence

    sequence sens_read;
        rd && addr == ffc_pkg::sens_offset;
    endsequence

    sens_hold_a: assert property (
        sens_read |=> rdata[3:0] == $past(sens) && rdata[31:4] == '0)
        else $error("sensitivity readback differs from stored value");
    sens_store_a: assert property (
        sens_written |=> sens == $past(wdata[3:0]))
        else $error("sensitivity write not stored");
    prog_frame_a: assert property (
        region_valid && progressive |=> region_frame_mode)
        else $error("progressive region not in frame mode");
    still_frame_a: assert property (
        region_valid && !moving |=> region_out_valid && region_frame_mode)
        else $error("still region not in frame mode");
    pulldown_field_a: assert property (
        region_valid && moving && !progressive &&
        film_mode == ffc_pkg::mode_pulldown |=> !region_frame_mode)
        else $error("three-two override did not force field mode");
    film_frame_a: assert property (
        region_valid && !progressive && film_mode == ffc_pkg::mode_film &&
        second_field |=> region_frame_mode)
        else $error("film override did not force frame on matching field");
    bypass_follow_a: assert property (
        unity_size [*2] |=> interp_bypass)
        else $error("unity size did not bypass interpolator");
    normal_rate_a: assert property (
        field_start && rate == ffc_pkg::mode_normal |=> position_advance)
        else $error("normal rate missed a field advance");
    idle_rate_a: assert property (
        !field_start |=> !position_advance)
        else $error("position advanced without a field");

    // a region whose input moves; only these can be bent by the override
    sequence moving_region;
        region_valid && moving && !progressive;
    endsequence

    sequence pulldown_field_taken;
        field_start && rate == ffc_pkg::mode_pulldown;
    endsequence

    normal_sens_a: assert property (
        moving_region ##0 (film_mode == ffc_pkg::mode_normal &&
        sens == ffc_pkg::sens_frame) |=> region_frame_mode)
        else $error("normal override did not follow sensitivity");
    film_other_a: assert property (
        moving_region ##0 (film_mode == ffc_pkg::mode_film &&
        !second_field && sens == ffc_pkg::sens_field) |=> !region_frame_mode)
        else $error("film override forced frame on an unmatched field");
    border_motion_a: assert property (
        region_valid && border_change && !progressive &&
        eff_sens == ffc_pkg::sens_field |=> !region_frame_mode)
        else $error("border change not treated as motion");
    effect_motion_a: assert property (
        region_valid && effect_motion && region_motion == '0 &&
        !border_change |=> region_frame_mode)
        else $error("effect motion treated as input motion");
    field_track_a: assert property (
        field_start |=> cur_field == $past(field_id))
        else $error("field identity not captured");
    film_rate_a: assert property (
        field_start && rate == ffc_pkg::mode_film &&
        field_id != rate_film_phase |=> !position_advance)
        else $error("film rate advanced on the wrong field");
    pulldown_skip_a: assert property (
        pulldown_field_taken ##0 (cad_idx != ffc_pkg::cadence_hit_a &&
        cad_idx != ffc_pkg::cadence_hit_b) |=> !position_advance)
        else $error("three-two rate advanced off the cadence");
    // out of range phase codes are clamped on write and the position wraps at five, so these never drift
    cadence_range_a: assert property (
        cad_pos < ffc_pkg::cadence_len && cad_phase < ffc_pkg::cadence_len)
        else $error("cadence position or phase out of range");
    mode_legal_a: assert property (
        film_mode != 2'h3 && rate != 2'h3)
        else $error("override or rate holds an illegal code");
    load_keeps_a: assert property (
        effect_load && !wr |=> $stable(sens) && $stable(film_mode) &&
        $stable(rate) && $stable(cad_phase))
        else $error("effect load or save moved a global setting");
    bypass_off_a: assert property (
        !unity_size |=> !interp_bypass)
        else $error("interpolator bypassed away from unity size");
    read_idle_a: assert property (
        !rd |=> rdata == ffc_pkg::read_zero)
        else $error("read data shown without a read");
    region_pulse_a: assert property (
        region_valid |=> region_out_valid)
        else $error("region decision not flagged valid");
    region_hold_a: assert property (
        !region_valid |=> $stable(region_frame_mode))
        else $error("region decision changed without a region");
endmodule

// ===== dv/video_source.sv
// interlaced source model driving field starts and field identity
`timescale 1ns/1ps
module video_source (
    input wire logic clk,
    output logic field_start,
    output logic field_id
);
    initial
    begin
        field_start = 1'b0;
        field_id = 1'b0;
    end
    // id is only meaningful with the pulse, so it shows the inverse after
    task automatic send(input logic id);
        @(posedge clk);
        field_start <= 1'b1;
        field_id <= id;
        @(posedge clk);
        field_start <= 1'b0;
        field_id <= ~id;
    endtask
endmodule

// ===== dv/motion_adaptive_field_frame_control_bench.sv
// self-checking bench for the field/frame control block
`timescale 1ns/1ps
module motion_adaptive_field_frame_control_bench;
    logic clk, arst_n, wr, rd, progressive, unity_size, effect_load;
    logic region_valid, border_change, effect_motion;
    logic [3:0] addr, region_motion;
    logic [31:0] wdata, rdata, v;
    logic field_start, field_id, region_out_valid, region_frame_mode;
    logic interp_bypass, position_advance;
    int n_mismatch, checks_done;
    // ======================================================
    // design and source model
    field_frame_ctrl uut (.clk(clk), .arst_n(arst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .field_start(field_start), .field_id(field_id),
        .progressive(progressive), .unity_size(unity_size),
        .effect_load(effect_load), .region_valid(region_valid),
        .region_motion(region_motion), .border_change(border_change),
        .effect_motion(effect_motion),
        .region_out_valid(region_out_valid),
        .region_frame_mode(region_frame_mode),
        .interp_bypass(interp_bypass),
        .position_advance(position_advance));
    video_source src (.clk(clk), .field_start(field_start),
        .field_id(field_id));
    // ======================================================
    // shared tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("FAIL t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd_reg(a, d);
        chk(d, e);
    endtask
    task automatic rg(input logic [3:0] m, input logic b, input logic e,
        input logic x);
        @(posedge clk);
        region_valid <= 1'b1;
        region_motion <= m;
        border_change <= b;
        effect_motion <= e;
        @(posedge clk);
        region_valid <= 1'b0;
        #1 chk(32'(region_out_valid), 32'h0000_0001);
        chk(32'(region_frame_mode), 32'(x));
    endtask
    task automatic fld(input logic id, input logic x);
        src.send(id);
        #1 chk(32'(position_advance), 32'(x));
    endtask
    task automatic give_verdict;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ======================================================
    // scenarios
    task automatic t_reset;
        rd_chk(4'h0, 32'h0000_0009);
        rd_chk(4'h4, 32'h0000_0000);
        rd_chk(4'h8, 32'h0000_0000);
        rd_chk(4'h2, 32'h0000_0000);
    endtask
    task automatic t_levels;
        wr_reg(4'h0, 32'h0000_0000);
        rg(4'hf, 1'b0, 1'b0, 1'b1);
        wr_reg(4'h0, 32'h0000_000f);
        rg(4'h1, 1'b0, 1'b0, 1'b0);
        wr_reg(4'h0, 32'h0000_0009);
        rg(4'h7, 1'b0, 1'b0, 1'b0);
        rg(4'h6, 1'b0, 1'b0, 1'b1);
        wr_reg(4'h0, 32'h0000_000f);
        rg(4'h0, 1'b0, 1'b0, 1'b1);
        rg(4'h0, 1'b1, 1'b0, 1'b0);
        rg(4'h0, 1'b0, 1'b1, 1'b1);
        @(posedge clk);
        progressive <= 1'b1;
        rg(4'hf, 1'b0, 1'b0, 1'b1);
        @(posedge clk);
        progressive <= 1'b0;
    endtask
    task automatic t_film;
        wr_reg(4'h4, 32'h0000_0001);
        src.send(1'b1);
        rg(4'h5, 1'b0, 1'b0, 1'b1);
        src.send(1'b0);
        rg(4'h5, 1'b0, 1'b0, 1'b0);
        wr_reg(4'h4, 32'h0000_0005);
        rg(4'h5, 1'b0, 1'b0, 1'b1);
        rd_chk(4'h0, 32'h0000_000f);
        wr_reg(4'h0, 32'h0000_0000);
        wr_reg(4'h4, 32'h0000_0002);
        rg(4'h1, 1'b0, 1'b0, 1'b0);
        wr_reg(4'h4, 32'h0000_0003);
        rd_chk(4'h4, 32'h0000_0000);
    endtask
    task automatic t_rate;
        int pos;
        fld(1'b0, 1'b1);
        fld(1'b1, 1'b1);
        wr_reg(4'h8, 32'h0000_0001);
        fld(1'b0, 1'b1);
        fld(1'b1, 1'b0);
        wr_reg(4'h8, 32'h0000_0005);
        fld(1'b0, 1'b0);
        wr_reg(4'h4, 32'h0000_0001);
        wr_reg(4'h8, 32'h0000_0000);
        fld(1'b0, 1'b1);
        wr_reg(4'h8, 32'h0000_0032);
        rd_reg(4'hc, v);
        chk(v, 32'h0000_0030);
        pos = 3;
        for (int i = 0; i < 10; i++)
        begin
            fld(i[0], ((pos + 3) % 5 == 0) || ((pos + 3) % 5 == 3));
            pos = (pos + 1) % 5;
        end
        wr_reg(4'h8, 32'h0000_0072);
        rd_chk(4'h8, 32'h0000_0042);
    endtask
    task automatic t_misc;
        @(posedge clk);
        unity_size <= 1'b1;
        effect_load <= 1'b1;
        @(posedge clk);
        effect_load <= 1'b0;
        #1 chk(32'(interp_bypass), 32'h0000_0001);
        @(posedge clk);
        unity_size <= 1'b0;
        rd_chk(4'h4, 32'h0000_0001);
        chk(32'(interp_bypass), 32'h0000_0000);
        rd_chk(4'h8, 32'h0000_0042);
    endtask
    // ======================================================
    // clock, reset, sequence and watchdog
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
    initial
    begin
        {arst_n, wr, rd, progressive, unity_size, effect_load} = 6'h00;
        {region_valid, border_change, effect_motion} = 3'h0;
        addr = 4'h0;
        region_motion = 4'h0;
        wdata = 32'h0000_0000;
        n_mismatch = 0;
        checks_done = 0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_levels();
        t_film();
        t_rate();
        t_misc();
        give_verdict();
    end
endmodule
